// ==== logic/cpsr_pkg.sv ====
// constants and types for the status and bank-3 register block
package cpsr_pkg;

  // bus and register widths
  localparam int          WB_DW      = 32;
  localparam int          WB_AW      = 11;
  localparam int          REG_W      = 8;
  localparam int          IDX_W      = 9;

  // register indexes; byte address is four times the index
  localparam logic [8:0]  IDX_INDIRECT_PORT   = 9'h180;
  localparam logic [8:0]  IDX_OPTION_CONFIG   = 9'h181;
  localparam logic [8:0]  IDX_PC_LOW          = 9'h182;
  localparam logic [8:0]  IDX_ARITH_FLAGS     = 9'h183;
  localparam logic [8:0]  IDX_INDIRECT_PTR    = 9'h184;
  localparam logic [8:0]  IDX_PORT_B_DIR      = 9'h186;
  localparam logic [8:0]  IDX_PORT_F_DIR      = 9'h187;
  localparam logic [8:0]  IDX_PORT_G_DIR      = 9'h188;
  localparam logic [8:0]  IDX_PC_HIGH_LATCH   = 9'h18a;
  localparam logic [8:0]  IDX_INTERRUPT_CTRL  = 9'h18b;
  localparam logic [8:0]  IDX_PM_DATA_LOW     = 9'h18c;
  localparam logic [8:0]  IDX_PM_ADDR_LOW     = 9'h18d;
  localparam logic [8:0]  IDX_PM_DATA_HIGH    = 9'h18e;
  localparam logic [8:0]  IDX_PM_ADDR_HIGH    = 9'h18f;
  // status alias: same low seven index bits in every bank
  localparam logic [6:0]  STATUS_ALIAS_LOW    = 7'h03;
  localparam logic [4:0]  BANK3_BLOCK         = 5'h18;

  // status bit positions, plus option prescaler-select bit and low-nibble msb
  localparam int          BIT_IBS    = 7;
  localparam int          BIT_RP_HI  = 6;
  localparam int          BIT_RP_LO  = 5;
  localparam int          BIT_TO_N   = 4;
  localparam int          BIT_PWD_N  = 3;
  localparam int          BIT_Z      = 2;
  localparam int          BIT_DGC    = 1;
  localparam int          BIT_C      = 0;
  localparam int          BIT_PSEL   = 3;
  localparam int          NIB_MSB    = 3;

  // plain register reset values and writable masks, by low index nibble
  localparam logic [7:0]  PLAIN_RESET [16] = '{
    8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
    8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0]  PLAIN_MASK  [16] = '{
    8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff,
    8'hff, 8'h00, 8'h1f, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h1f};

  // ALU operations, one-hot
  typedef enum logic [7:0] {
    ALU_ADD   = 8'h01,
    ALU_SUB   = 8'h02,
    ALU_AND   = 8'h04,
    ALU_OR    = 8'h08,
    ALU_XOR   = 8'h10,
    ALU_ROTL  = 8'h20,
    ALU_ROTR  = 8'h40,
    ALU_CLEAR = 8'h80
  } cpsr_alu_op_t;

endpackage : cpsr_pkg

// ==== logic/cpsr_status_bank3.sv ====
// status register, bank-3 register map and flag-producing ALU
//
// Operation
// [RULE1] ALU op writing status keeps Z, DC, C from the ALU, not the result; here logic ops take DC and C, and rotates take Z and DC, from the result
// [RULE2] time-out and power-down flags ignore every instruction or bus write
// [RULE3] clearing status zeroes bank bits, sets Z, keeps other flags
// [RULE4] software should alter status only with bit, swap or move writes
// [RULE5] indirect bank bit 7 picks banks 2-3 when 1, banks 0-1 when 0
// [RULE6] direct bank bits 6:5 choose bank 0 to 3 for direct addressing
// [RULE7] time-out flag set by reset, watchdog clear, sleep; cleared by timeout
// [RULE8] power-down flag set by reset or watchdog clear; cleared by sleep
// [RULE9] zero flag set when affecting result is zero, else cleared
// [RULE10] digit carry is carry out of low nibble; inverted for subtract
// [RULE11] carry is carry out of result msb; zero means borrow on subtract
// [RULE12] subtract adds the two's complement of the second operand
// [RULE13] rotates load carry with the bit shifted out of the source
// [RULE14] status reachable at 03h, 83h, 103h and 183h, one register
// [RULE15] software assigns prescaler to watchdog for a 1:1 timer rate
// [RULE16] prescaler assign bit 3 routes prescaler to watchdog when 1
// [RULE17] unimplemented bank-3 locations ignore writes and read zero
// [RULE18] reset clears bank bits and sets time-out and power-down flags
//
// Design decision made here: register access over Wishbone.
module cpsr_status_bank3
  import cpsr_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [WB_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [WB_DW-1:0]   wb_dat_i,
  output logic      [WB_DW-1:0]   wb_dat_o,
  output logic                    wb_ack_o,
  // instruction execution side
  input  wire logic               aluValid,
  input  wire cpsr_alu_op_t       aluOp,
  input  wire logic [REG_W-1:0]   aluOperandA,
  input  wire logic [REG_W-1:0]   aluOperandB,
  input  wire logic               aluDestStatus,
  output logic      [REG_W-1:0]   aluResult,
  output logic                    aluResultValid,
  // hardware reset-status events
  input  wire logic               watchdogClearInstr,
  input  wire logic               sleepInstr,
  input  wire logic               watchdogTimeout,
  // state to the core
  output logic                    indirectBankSelect,
  output logic      [1:0]         directBankSelect,
  output logic      [IDX_W-1:0]   indirectAddress,
  output logic                    timeoutFlagN,
  output logic                    powerdownFlagN,
  output logic                    zeroFlag,
  output logic                    digitCarryFlag,
  output logic                    carryFlag,
  output logic                    prescalerToWatchdog
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic isStatus(input logic [IDX_W-1:0] idx);
    isStatus = (idx[6:0] == STATUS_ALIAS_LOW);
  endfunction : isStatus

  function automatic logic isPlain(input logic [IDX_W-1:0] idx);
    isPlain = (idx[8:4] == BANK3_BLOCK) && (PLAIN_MASK[idx[3:0]] != 8'h00);
  endfunction : isPlain

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  logic              wbAck_q;
  logic [WB_DW-1:0]  wbDat_q;
  logic [IDX_W-1:0]  wbIdx;
  logic              wbReq;
  logic              wbWrite;
  logic [REG_W-1:0]  wbByte;
  logic [REG_W-1:0]  statusWord;
  logic [REG_W-1:0]  readByte;
  logic [REG_W-1:0]  plain_q [16];

  assign wbIdx   = wb_adr_i[WB_AW-1:2];
  assign wbReq   = wb_cyc_i && wb_stb_i;
  // write lands on the same edge the master sees ack
  assign wbWrite = wbReq && wb_we_i && wbAck_q && wb_sel_i[0];
  assign wbByte  = wb_dat_i[REG_W-1:0];

  always_comb begin
    // [RULE14] every alias reads one register
    if (isStatus(wbIdx)) begin
      readByte = statusWord;
    end else if (isPlain(wbIdx)) begin
      readByte = plain_q[wbIdx[3:0]] & PLAIN_MASK[wbIdx[3:0]];
    end else begin
      // [RULE17] holes read zero
      readByte = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wbAck_q <= 1'b0;
    end else begin
      wbAck_q <= wbReq && !wbAck_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wbDat_q <= '0;
    end else if (wbReq && !wbAck_q) begin
      wbDat_q <= {{(WB_DW-REG_W){1'b0}}, readByte};
    end
  end

  assign wb_ack_o = wbAck_q;
  assign wb_dat_o = wbDat_q;

  ////////////////////////////////////////////////////////////////////////////
  // plain registers; indirect port holds nothing so it reads zero

  for (genvar i = 0; i < 16; i++) begin : g_plain
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        plain_q[i] <= PLAIN_RESET[i];
      end else if (wbWrite && isPlain(wbIdx) && (wbIdx[3:0] == 4'(i))) begin
        // [RULE17] only implemented bits store
        plain_q[i] <= wbByte & PLAIN_MASK[i];
      end
    end
  end

  // [RULE16] prescaler routing
  assign prescalerToWatchdog = plain_q[IDX_OPTION_CONFIG[3:0]][BIT_PSEL];

  ////////////////////////////////////////////////////////////////////////////
  // ALU

  logic              isAdd;
  logic              isSub;
  logic              isLogic;
  logic              isRot;
  logic              isClear;
  logic [REG_W-1:0]  addend;
  logic [REG_W:0]    sumFull;
  logic [4:0]        sumNib;
  logic [REG_W-1:0]  res;
  logic              resCarry;
  logic              resZero;

  assign isAdd   = aluOp == ALU_ADD;
  assign isSub   = aluOp == ALU_SUB;
  assign isLogic = (aluOp == ALU_AND) || (aluOp == ALU_OR) || (aluOp == ALU_XOR);
  assign isRot   = (aluOp == ALU_ROTL) || (aluOp == ALU_ROTR);
  assign isClear = aluOp == ALU_CLEAR;

  // [RULE12] subtract via two's complement add
  assign addend  = isSub ? ~aluOperandB : aluOperandB;
  assign sumFull = {1'b0, aluOperandA} + {1'b0, addend} + {{REG_W{1'b0}}, isSub};
  assign sumNib  = {1'b0, aluOperandA[NIB_MSB:0]} + {1'b0, addend[NIB_MSB:0]} + {4'h0, isSub};

  always_comb begin
    res      = 8'h00;
    resCarry = carryFlag;
    case (aluOp)
      ALU_ADD, ALU_SUB: begin
        res      = sumFull[REG_W-1:0];
        resCarry = sumFull[REG_W];
      end
      ALU_AND: res = aluOperandA & aluOperandB;
      ALU_OR:  res = aluOperandA | aluOperandB;
      ALU_XOR: res = aluOperandA ^ aluOperandB;
      // [RULE13] carry takes the bit shifted out
      ALU_ROTL: begin
        res      = {aluOperandA[REG_W-2:0], carryFlag};
        resCarry = aluOperandA[REG_W-1];
      end
      ALU_ROTR: begin
        res      = {carryFlag, aluOperandA[REG_W-1:1]};
        resCarry = aluOperandA[0];
      end
      ALU_CLEAR: res = 8'h00;
      default:   res = 8'h00;
    endcase
  end

  assign resZero = (res == 8'h00);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      aluResult      <= 8'h00;
      aluResultValid <= 1'b0;
    end else begin
      aluResult      <= res;
      aluResultValid <= aluValid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register

  logic        ibs_q;
  logic [1:0]  rp_q;
  logic        toN_q;
  logic        pwdN_q;
  logic        z_q;
  logic        dgc_q;
  logic        c_q;
  logic        aluToStatus;
  logic        busToStatus;

  assign aluToStatus = aluValid && aluDestStatus;
  // a bus write colliding with an ALU flag update loses the flag bits
  assign busToStatus = wbWrite && isStatus(wbIdx);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      // [RULE18] bank bits cleared at reset
      ibs_q <= 1'b0;
      rp_q  <= 2'b00;
    end else if (aluToStatus) begin
      // [RULE3] clear lands here as zero bank bits
      ibs_q <= res[BIT_IBS];
      rp_q  <= res[BIT_RP_HI:BIT_RP_LO];
    end else if (busToStatus) begin
      ibs_q <= wbByte[BIT_IBS];
      rp_q  <= wbByte[BIT_RP_HI:BIT_RP_LO];
    end
  end

  // [RULE2] no write path; only reset and hardware events
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      toN_q <= 1'b1;
    end else if (watchdogTimeout) begin
      // [RULE7] timeout wins a same-cycle clear
      toN_q <= 1'b0;
    end else if (watchdogClearInstr || sleepInstr) begin
      toN_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pwdN_q <= 1'b1;
    end else if (sleepInstr) begin
      // [RULE8] sleep clears, watchdog clear sets
      pwdN_q <= 1'b0;
    end else if (watchdogClearInstr) begin
      pwdN_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      z_q <= 1'b0;
    end else if (aluValid && (isAdd || isSub || isLogic || isClear)) begin
      // [RULE9] zero from the result; [RULE1] not from the write
      z_q <= resZero;
    end else if (aluToStatus) begin
      z_q <= res[BIT_Z];
    end else if (busToStatus) begin
      z_q <= wbByte[BIT_Z];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dgc_q <= 1'b0;
    end else if (aluValid && (isAdd || isSub)) begin
      // [RULE10] nibble carry, borrow inverted by the add form
      dgc_q <= sumNib[NIB_MSB+1];
    end else if (aluToStatus && !isClear) begin
      dgc_q <= res[BIT_DGC];
    end else if (busToStatus) begin
      dgc_q <= wbByte[BIT_DGC];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      c_q <= 1'b0;
    end else if (aluValid && (isAdd || isSub || isRot)) begin
      // [RULE11] msb carry; [RULE1] flag beats destination write
      c_q <= resCarry;
    end else if (aluToStatus && !isClear) begin
      c_q <= res[BIT_C];
    end else if (busToStatus) begin
      c_q <= wbByte[BIT_C];
    end
  end

  assign statusWord         = {ibs_q, rp_q, toN_q, pwdN_q, z_q, dgc_q, c_q};
  // [RULE5] indirect upper half when set
  assign indirectBankSelect = ibs_q;
  assign indirectAddress    = {ibs_q, plain_q[IDX_INDIRECT_PTR[3:0]]};
  // [RULE6] direct bank select
  assign directBankSelect   = rp_q;
  assign timeoutFlagN       = toN_q;
  assign powerdownFlagN     = pwdN_q;
  assign zeroFlag           = z_q;
  assign digitCarryFlag     = dgc_q;
  assign carryFlag          = c_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_busRead;
    wbReq && !wb_we_i && !wbAck_q;
  endsequence

  sequence s_ackZero;
    wbAck_q && (wbDat_q == '0);
  endsequence

  property p_flagsFromAlu;
    aluValid && aluDestStatus && isAdd |=> (z_q == $past(resZero)) && (c_q == $past(sumFull[REG_W]));
  endproperty
  a_flagsFromAlu: assert property (p_flagsFromAlu) else $error("status dest overwrote flags"); // [RULE1]

  property p_readOnlyFlags;
    wbWrite && isStatus(wbIdx) && !watchdogTimeout && !watchdogClearInstr && !sleepInstr
      |=> $stable(toN_q) && $stable(pwdN_q);
  endproperty
  a_readOnlyFlags: assert property (p_readOnlyFlags) else $error("reset flags took a write"); // [RULE2]

  property p_clearStatus;
    aluValid && aluDestStatus && isClear
      |=> !ibs_q && (rp_q == 2'b00) && z_q && $stable(dgc_q) && $stable(c_q);
  endproperty
  a_clearStatus: assert property (p_clearStatus) else $error("status clear wrong"); // [RULE3]

  property p_timeout;
    watchdogTimeout |=> !toN_q;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag not cleared"); // [RULE7]

  property p_sleep;
    sleepInstr && !watchdogTimeout |=> !pwdN_q && toN_q;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong"); // [RULE8]
  property p_subBorrow;
    aluValid && isSub |=> (c_q == ($past(aluOperandA) >= $past(aluOperandB)));
  endproperty
  a_subBorrow: assert property (p_subBorrow) else $error("borrow sense wrong"); // [RULE11]
  property p_rotLeft;
    aluValid && (aluOp == ALU_ROTL) |=> (c_q == $past(aluOperandA[REG_W-1]));
  endproperty
  a_rotLeft: assert property (p_rotLeft) else $error("rotate carry wrong"); // [RULE13]
  property p_holeReadsZero;
    (s_busRead and (!isStatus(wbIdx) && !isPlain(wbIdx))) |=> s_ackZero;
  endproperty
  a_holeReadsZero: assert property (p_holeReadsZero) else $error("hole read nonzero"); // [RULE17]
  property p_aliasRead;
    (s_busRead and isStatus(wbIdx)) |=> wbAck_q && (wbDat_q[REG_W-1:0] == $past(statusWord));
  endproperty
  a_aliasRead: assert property (p_aliasRead) else $error("status alias mismatch"); // [RULE14]
  property p_preWrite;
    wbWrite && (wbIdx == IDX_OPTION_CONFIG) |=> prescalerToWatchdog == $past(wbByte[BIT_PSEL]);
  endproperty
  a_preWrite: assert property (p_preWrite) else $error("prescaler routing stale"); // [RULE16]
endmodule : cpsr_status_bank3

// ==== test/cpsr_core_model.sv ====
// instruction-side model: ALU requests and reset-status events
module cpsr_core_model
  import cpsr_pkg::*;
(
  // clock
  input  wire logic         sys_clk,
  // alu request
  output cpsr_alu_op_t      aluOp,
  output logic              aluValid,
  output logic [REG_W-1:0]  aluOperandA,
  output logic [REG_W-1:0]  aluOperandB,
  output logic              aluDestStatus,
  // reset-status events
  output logic              watchdogClearInstr,
  output logic              sleepInstr,
  output logic              watchdogTimeout
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {aluValid, aluDestStatus} = 2'b00;
    {watchdogClearInstr, sleepInstr, watchdogTimeout} = 3'b000;
    aluOp = ALU_ADD;
    aluOperandA = 8'h00;
    aluOperandB = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one op per call; operands scrambled after use so stale values never match
  task automatic alu(input cpsr_alu_op_t op, input logic [7:0] a, input logic [7:0] b, input logic dst);
    @(posedge sys_clk);
    aluValid <= 1'b1;
    aluOp <= op;
    aluOperandA <= a;
    aluOperandB <= b;
    aluDestStatus <= dst;
    @(posedge sys_clk);
    aluValid <= 1'b0;
    aluDestStatus <= 1'b0;
    aluOperandA <= ~a;
    aluOperandB <= ~b;
  endtask : alu

  task automatic event_pulse(input int which);
    @(posedge sys_clk);
    watchdogTimeout <= (which == 0);
    watchdogClearInstr <= (which == 1);
    sleepInstr <= (which == 2);
    @(posedge sys_clk);
    {watchdogTimeout, watchdogClearInstr, sleepInstr} <= 3'b000;
  endtask : event_pulse
endmodule : cpsr_core_model

// ==== test/cpsr_status_bank3_test.sv ====
// self-checking bench for the status and bank-3 register block
module cpsr_status_bank3_test import cpsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic              sys_clk, rst_b;
  logic              wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [WB_AW-1:0]  wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [WB_DW-1:0]  wb_dat_i, wb_dat_o;
  cpsr_alu_op_t      aluOp;
  logic              aluValid, aluDestStatus, aluResultValid;
  logic [REG_W-1:0]  aluOperandA, aluOperandB, aluResult;
  logic              watchdogClearInstr, sleepInstr, watchdogTimeout;
  logic              indirectBankSelect, timeoutFlagN, powerdownFlagN, prescalerToWatchdog;
  logic              zeroFlag, digitCarryFlag, carryFlag;
  logic [1:0]        directBankSelect;
  logic [IDX_W-1:0]  indirectAddress;
  int                nFail, checked;
  logic              eZ, eDc, eC;
  logic [7:0]        rdv;
  // register map walk: index, reset value, readback after writing all ones
  localparam logic [8:0] IDX [15] = '{9'h180, 9'h181, 9'h182, 9'h184, 9'h185, 9'h186, 9'h187, 9'h188,
                                      9'h189, 9'h18a, 9'h18b, 9'h18c, 9'h18d, 9'h18e, 9'h18f};
  localparam logic [7:0] RST [15] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff,
                                      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WMK [15] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff,
                                      8'h00, 8'h1f, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h1f};

  cpsr_status_bank3 u_dut (
    .sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .aluValid, .aluOp, .aluOperandA, .aluOperandB, .aluDestStatus, .aluResult, .aluResultValid,
    .watchdogClearInstr, .sleepInstr, .watchdogTimeout, .indirectBankSelect, .directBankSelect,
    .indirectAddress, .timeoutFlagN, .powerdownFlagN, .zeroFlag, .digitCarryFlag, .carryFlag,
    .prescalerToWatchdog);

  cpsr_core_model u_core (
    .sys_clk, .aluOp, .aluValid, .aluOperandA, .aluOperandB, .aluDestStatus,
    .watchdogClearInstr, .sleepInstr, .watchdogTimeout);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chkv(input string nm, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chkv

  task automatic chk1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      nFail++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // classic cycle: hold everything until ack, then release for a cycle
  task automatic wb_xfer(input logic we, input logic [8:0] idx, input logic [7:0] wd, input logic [3:0] sel);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, wd};
    n = 0;
    // look mid-cycle: ack then holds what the next rising edge samples
    do begin
      @(negedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1) begin
      nFail++;
      give_verdict();
    end
    // write lands and data is taken on this edge; release only after it
    @(posedge sys_clk);
    rdv = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(negedge sys_clk);
  endtask : wb_xfer

  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    wb_xfer(1'b1, idx, d, 4'hf);
  endtask : wr

  task automatic rd_chk(input logic [8:0] idx, input logic [7:0] e, input string nm);
    wb_xfer(1'b0, idx, 8'h00, 4'hf);
    chkv(nm, {1'b0, e}, {1'b0, rdv});
  endtask : rd_chk

  task automatic ev(input int which, input logic eTo, input logic ePd);
    u_core.event_pulse(which);
    @(negedge sys_clk);
    chk1("timeout flag", eTo, timeoutFlagN);
    chk1("powerdown flag", ePd, powerdownFlagN);
  endtask : ev

  // expected result and flags worked out from the add/borrow definitions
  task automatic alu_chk(input cpsr_alu_op_t op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [7:0] bb;
    bb = (op == ALU_SUB) ? ~b : b;
    s = a + bb + (op == ALU_SUB);
    h = a[3:0] + bb[3:0] + (op == ALU_SUB);
    case (op)
      ALU_ADD, ALU_SUB: begin
        r = s[7:0];
        eC = s[8];
        eDc = h[4];
      end
      ALU_AND: r = a & b;
      ALU_OR: r = a | b;
      ALU_XOR: r = a ^ b;
      ALU_ROTL: begin
        r = {a[6:0], eC};
        eC = a[7];
      end
      ALU_ROTR: begin
        r = {eC, a[7:1]};
        eC = a[0];
      end
      default: r = 8'h00;
    endcase
    if (!(op inside {ALU_ROTL, ALU_ROTR})) eZ = (r == 8'h00);
    u_core.alu(op, a, b, 1'b0);
    @(negedge sys_clk);
    chk1("result valid", 1'b1, aluResultValid);
    chkv("alu result", {1'b0, r}, {1'b0, aluResult});
    chk1("zero", eZ, zeroFlag);
    chk1("digit carry", eDc, digitCarryFlag);
    chk1("carry", eC, carryFlag);
  endtask : alu_chk

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
    wb_adr_i = '0;
    wb_sel_i = 4'hf;
    wb_dat_i = '0;
    rst_b = 1'b0;
    nFail = 0;
    checked = 0;
    {eZ, eDc, eC} = 3'b000;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk1("prescaler route", 1'b1, prescalerToWatchdog);
    rd_chk(9'h183, 8'h18, "status reset");
    for (int i = 0; i < 15; i++) rd_chk(IDX[i], RST[i], "reset value");
    for (int i = 0; i < 15; i++) begin
      wr(IDX[i], 8'hff);
      rd_chk(IDX[i], WMK[i], "written value");
    end
    wr(9'h181, 8'hf7);
    chk1("prescaler route", 1'b0, prescalerToWatchdog);
    wr(9'h181, 8'h08);
    wb_xfer(1'b1, 9'h181, 8'h00, 4'he);
    rd_chk(9'h181, 8'h08, "byte-lane write");
    chk1("prescaler route", 1'b1, prescalerToWatchdog);
    wr(9'h003, 8'h00);
    rd_chk(9'h183, 8'h18, "status alias");
    wr(9'h083, 8'he5);
    rd_chk(9'h103, 8'hfd, "status alias");
    chk1("indirect bank", 1'b1, indirectBankSelect);
    chkv("indirect addr", 9'h1ff, indirectAddress);
    for (int k = 0; k < 4; k++) begin
      wr(9'h183, 8'(k << 5));
      chkv("direct bank", 9'(k), {7'h00, directBankSelect});
    end
    chkv("indirect addr", 9'h0ff, indirectAddress);
    ev(0, 1'b0, 1'b1);
    ev(2, 1'b1, 1'b0);
    wr(9'h183, 8'h78);
    rd_chk(9'h183, 8'h70, "status read-only bits");
    ev(1, 1'b1, 1'b1);
    alu_chk(ALU_SUB, 8'h05, 8'h07);
    alu_chk(ALU_SUB, 8'h10, 8'h01);
    alu_chk(ALU_ADD, 8'h08, 8'h08);
    alu_chk(ALU_ADD, 8'hff, 8'h01);
    alu_chk(ALU_AND, 8'hf0, 8'h0f);
    alu_chk(ALU_OR, 8'h40, 8'h01);
    alu_chk(ALU_XOR, 8'h5a, 8'h5a);
    alu_chk(ALU_ROTL, 8'h81, 8'h00);
    alu_chk(ALU_ROTR, 8'h02, 8'h00);
    alu_chk(ALU_ROTR, 8'h01, 8'h00);
    u_core.alu(ALU_ADD, 8'he8, 8'h08, 1'b1);
    @(negedge sys_clk);
    chkv("bank bits", 9'h007, {6'h00, indirectBankSelect, directBankSelect});
    chk1("zero", 1'b0, zeroFlag);
    chk1("digit carry", 1'b1, digitCarryFlag);
    chk1("carry", 1'b0, carryFlag);
    ev(0, 1'b0, 1'b1);
    u_core.alu(ALU_CLEAR, 8'h00, 8'h00, 1'b1);
    @(negedge sys_clk);
    chkv("bank bits", 9'h000, {6'h00, indirectBankSelect, directBankSelect});
    chk1("zero", 1'b1, zeroFlag);
    chk1("digit carry", 1'b1, digitCarryFlag);
    chk1("carry", 1'b0, carryFlag);
    chk1("timeout flag", 1'b0, timeoutFlagN);
    give_verdict();
  end
endmodule : cpsr_status_bank3_test
